// [src/dual_fifo_pkg.sv]
// Constants and encodings shared by the dual datapath FIFO block
package dual_fifo_pkg;
    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 4;
    localparam int BYTE_W = 8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int HALF_LEVEL = 2;
    localparam int CLK_PERIOD_NS = 5;
    // ------------------------------------------------------------
    // Source select codes
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_BUS = 2'h0;
    localparam logic [1:0] SRC_ACC0 = 2'h1;
    localparam logic [1:0] SRC_ACC1 = 2'h2;
    localparam logic [1:0] SRC_ALU = 2'h3;
    // ------------------------------------------------------------
    // Status synchronisation modes
    // ------------------------------------------------------------
    localparam logic [1:0] SYNC_DIRECT = 2'h0;
    localparam logic [1:0] SYNC_ONCE = 2'h1;
    localparam logic [1:0] SYNC_TWICE = 2'h2;
    // ------------------------------------------------------------
    // Bus target codes
    // ------------------------------------------------------------
    localparam logic [2:0] TGT_FIFO0 = 3'h0;
    localparam logic [2:0] TGT_FIFO1 = 3'h1;
    localparam logic [2:0] TGT_ACC0 = 3'h2;
    localparam logic [2:0] TGT_ACC1 = 3'h3;
    localparam logic [2:0] TGT_DATA0 = 3'h4;
    localparam logic [2:0] TGT_DATA1 = 3'h5;
endpackage : dual_fifo_pkg

// [src/fifo_port_if.sv]
// Interface between the block top and one byte FIFO
`timescale 1ns/10ps
interface fifo_port_if #(parameter int DEPTH = 4, parameter int WIDTH = 8);
    logic push;
    logic [WIDTH-1:0] push_data;
    logic pop;
    logic [WIDTH-1:0] pop_data;
    logic single;
    logic wipe;
    logic [$clog2(DEPTH):0] fill;
    modport core (input push, push_data, pop, single, wipe, output pop_data, fill);
    modport user (output push, push_data, pop, single, wipe, input pop_data, fill);
endinterface : fifo_port_if

// [src/byte_fifo.sv]
// One circular byte FIFO with single-buffer mode and overwrite on overflow
`timescale 1ns/10ps
module byte_fifo import dual_fifo_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int WIDTH = BYTE_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    fifo_port_if.core f
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("byte_fifo: DEPTH must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    wire [AW:0] level = wr_ptr_reg - rd_ptr_reg;
    wire full = (level == DEPTH_W);
    wire empty = (level == '0);
    wire do_pop = f.pop & ~empty & ~f.single;
    wire do_push = f.push & ~f.single & (~full | do_pop);
    wire overwrite = f.push & ~f.single & full & ~do_pop;
    wire [AW-1:0] wr_idx = wr_ptr_reg[AW-1:0];
    wire [AW-1:0] rd_idx = rd_ptr_reg[AW-1:0];

    // Output view; single-buffer mode shows the one held byte, no fill
    assign f.pop_data = f.single ? mem[0] : mem[rd_idx];
    assign f.fill = f.single ? '0 : level;

    // Pointers: held at zero in single mode, untouched by overwrite
    always_ff @(posedge clk_sys) begin
        if (rst || f.wipe || f.single) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(do_push); // [RULE_21]
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(do_pop); // [RULE_25]
        end
    end

    // Storage, cleared on reset and sleep
    always_ff @(posedge clk_sys) begin
        if (rst || f.wipe) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= RESET_BYTE;
            end
        end else if (f.single && f.push) begin
            mem[0] <= f.push_data; // [RULE_06]
        end else if (overwrite) begin
            mem[rd_idx] <= f.push_data; // [RULE_25]
        end else if (do_push) begin
            mem[wr_idx] <= f.push_data;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || f.wipe);

    a_overflow_keeps_ptrs: assert property (overwrite |=> level == DEPTH_W) // [RULE_25]
        else $error("overflow changed fill level");
    a_push_pop_same: assert property (f.push && f.pop && !empty && !full && !f.single
        |=> $stable(level)) // [RULE_21]
        else $error("simultaneous push and pop changed fill");
    a_single_readback: assert property (f.single && f.push ##1 f.single
        |-> f.pop_data == $past(f.push_data)) // [RULE_06]
        else $error("single buffer did not return written byte");
    a_fill_bounded: assert property (level <= DEPTH_W) // [RULE_01]
        else $error("fifo fill beyond depth");
endmodule : byte_fifo

// [src/datapath_dual_fifo.sv]
// Two datapath byte FIFOs with accumulators, data registers and status
//
// Contract
// RULE_01: Two four-byte FIFOs, each direction configurable.
// RULE_02: Sleep clears accumulators and FIFOs to zero.
// RULE_03: Data registers keep contents across sleep.
// RULE_04: Accumulators load from ALU, data register, FIFO.
// RULE_05: Input: bus writes, datapath reads; output reversed.
// RULE_06: Single-buffer: one byte, no status, overwritable.
// RULE_07: Load control selectable level or edge triggered.
// RULE_08: Level mode writes each sampled high cycle.
// RULE_09: Normal samples datapath clock, fast every cycle.
// RULE_10: Software capture: accumulator read loads its FIFO.
// RULE_11: Software capture passes along the chain upward.
// RULE_12: Block status direct, once or twice synchronised.
// RULE_13: Per-FIFO inverted datapath clock polarity bit.
// RULE_14: Source select: bus, accumulator zero, one, ALU.
// RULE_15: Input feeds registers; output sources accumulators, ALU.
// RULE_16: Each FIFO gives bus and block status.
// RULE_17: Input bus status: one or two free.
// RULE_18: Input block status signals empty.
// RULE_19: Output bus status: one or two readable.
// RULE_20: Output block status signals full.
// RULE_21: Same-cycle write and read handled correctly.
// RULE_22: Fast-mode load driver must meet system timing.
// RULE_23: Edge mode captures rising edge after low.
// RULE_24: Edges sampled at FIFO clock; one shared bit.
// RULE_25: Overflow overwrites front; pointers stay accurate.
// RULE_26: Reset leaves FIFOs empty, status matching empty; status outputs reset to zero; bus status, direct block status follow from the next edge.
`timescale 1ns/10ps
module datapath_dual_fifo import dual_fifo_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sleep,
    input wire logic dp_clk_rise_en,
    input wire logic dp_clk_fall_en,
    input wire logic [1:0] fifo_source_select_zero,
    input wire logic [1:0] fifo_source_select_one,
    input wire logic [1:0] fifo_level_threshold,
    input wire logic [1:0] fifo_clear,
    input wire logic [1:0] fifo_clk_invert,
    input wire logic edge_mode,
    input wire logic fast_mode,
    input wire logic sw_capture_en,
    input wire logic chain_enable,
    input wire logic [1:0] chain_capture_in,
    input wire logic [1:0] status_sync_mode,
    input wire logic [1:0] fifo_capture_load,
    input wire logic [7:0] alu_result,
    input wire logic [1:0] dp_acc_from_fifo,
    input wire logic [1:0] dp_data_from_fifo,
    input wire logic [1:0] dp_acc_from_data,
    input wire logic [1:0] dp_acc_from_alu,
    input wire logic bus_wr_en,
    input wire logic bus_rd_en,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wr_data,
    output logic [7:0] bus_rd_data,
    output logic [7:0] accumulator_zero,
    output logic [7:0] accumulator_one,
    output logic [7:0] data_reg_zero,
    output logic [7:0] data_reg_one,
    output logic [1:0] bus_status,
    output logic [1:0] block_status,
    output logic [1:0] chain_capture_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_W = (AW+1)'(HALF_LEVEL);

    initial begin
        if (DEPTH < HALF_LEVEL) begin
            $error("datapath_dual_fifo: DEPTH below half level threshold");
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic hits(input logic [2:0] addr, input logic [2:0] tgt);
        hits = (addr == tgt);
    endfunction : hits

    wire wr_fifo0 = bus_wr_en & hits(bus_addr, TGT_FIFO0);
    wire wr_fifo1 = bus_wr_en & hits(bus_addr, TGT_FIFO1);
    wire rd_fifo0 = bus_rd_en & hits(bus_addr, TGT_FIFO0);
    wire rd_fifo1 = bus_rd_en & hits(bus_addr, TGT_FIFO1);
    wire rd_acc0 = bus_rd_en & hits(bus_addr, TGT_ACC0);
    wire rd_acc1 = bus_rd_en & hits(bus_addr, TGT_ACC1);
    wire wr_acc0 = bus_wr_en & hits(bus_addr, TGT_ACC0);
    wire wr_acc1 = bus_wr_en & hits(bus_addr, TGT_ACC1);
    wire wr_data0 = bus_wr_en & hits(bus_addr, TGT_DATA0);
    wire wr_data1 = bus_wr_en & hits(bus_addr, TGT_DATA1);
    wire wipe = sleep;

    // ------------------------------------------------------------
    // Per-FIFO control
    // ------------------------------------------------------------
    wire [1:0] src_sel [2];
    assign src_sel[0] = fifo_source_select_zero;
    assign src_sel[1] = fifo_source_select_one;
    wire [1:0] bus_wr_fifo = {wr_fifo1, wr_fifo0};
    wire [1:0] bus_rd_fifo = {rd_fifo1, rd_fifo0};
    wire [1:0] bus_rd_acc = {rd_acc1, rd_acc0};

    logic [1:0] load_prev_reg;
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] chain_capture_out_next;
    logic [1:0] out_dir;
    logic [1:0] dp_en;
    logic [1:0] samp_en;
    logic [1:0] hw_trig;
    logic [1:0] sw_cap;
    logic [1:0] cap_fire;
    logic [1:0] bus_stat_raw;
    logic [1:0] blk_stat_raw;
    logic [1:0] blk_stat_sel;
    logic [7:0] fifo_out [2];

    fifo_port_if #(.DEPTH(DEPTH), .WIDTH(BYTE_W)) f_if [2] ();

    for (genvar i = 0; i < 2; i++) begin : g_fifo
        wire [AW:0] fill = f_if[i].fill;
        wire [AW:0] room = DEPTH_W - fill;
        wire single = fifo_clear[i];
        // Direction from source select: only the bus code is input
        assign out_dir[i] = (src_sel[i] != SRC_BUS); // [RULE_14]
        // FIFO clock phase: rising or inverted datapath clock
        assign dp_en[i] = fifo_clk_invert[i] ? dp_clk_fall_en : dp_clk_rise_en; // [RULE_13]
        // Load control sampled at datapath rate or every system cycle
        assign samp_en[i] = fast_mode | dp_en[i]; // [RULE_09] [RULE_22]
        // Level: fire while high; edge: fire on low-to-high only
        assign hw_trig[i] = samp_en[i] & fifo_capture_load[i]
            & (~edge_mode | ~load_prev_reg[i]); // [RULE_07] [RULE_08] [RULE_23] [RULE_24]
        // Accumulator read or chained neighbour read captures
        assign sw_cap[i] = sw_capture_en
            & (bus_rd_acc[i] | (chain_enable & chain_capture_in[i])); // [RULE_10] [RULE_11]
        assign cap_fire[i] = out_dir[i] & (hw_trig[i] | sw_cap[i]);
        assign chain_capture_out_next[i] = sw_cap[i];

        // Write side: bus in input direction, capture source otherwise
        assign f_if[i].push = out_dir[i] ? cap_fire[i] : bus_wr_fifo[i]; // [RULE_05]
        assign f_if[i].push_data = (src_sel[i] == SRC_ACC0) ? accumulator_zero :
                                   (src_sel[i] == SRC_ACC1) ? accumulator_one :
                                   (src_sel[i] == SRC_ALU) ? alu_result :
                                   bus_wr_data; // [RULE_14] [RULE_15]
        // Read side: datapath load in input direction, bus otherwise
        assign f_if[i].pop = out_dir[i] ? bus_rd_fifo[i]
            : (dp_en[i] & (dp_acc_from_fifo[i] | dp_data_from_fifo[i])); // [RULE_05] [RULE_15]
        assign f_if[i].single = single;
        assign f_if[i].wipe = wipe;
        assign fifo_out[i] = f_if[i].pop_data;

        // Bus status: threshold on free room or on readable bytes
        assign bus_stat_raw[i] = single ? 1'b0 :
            out_dir[i] ? (fifo_level_threshold[i] ? fill >= HALF_W : fill != '0) // [RULE_19]
                       : (fifo_level_threshold[i] ? room >= HALF_W : room != '0); // [RULE_17]
        // Block status: full for output, empty for input
        assign blk_stat_raw[i] = single ? 1'b0 :
            out_dir[i] ? (fill == DEPTH_W) : (fill == '0); // [RULE_18] [RULE_20]
        // Output status of the chosen synchronisation depth
        assign blk_stat_sel[i] = (status_sync_mode == SYNC_ONCE) ? sync1_reg[i] :
                                 (status_sync_mode == SYNC_TWICE) ? sync2_reg[i] :
                                 blk_stat_raw[i]; // [RULE_12]

        byte_fifo #(.DEPTH(DEPTH), .WIDTH(BYTE_W)) u_fifo (
            .clk_sys(clk_sys),
            .rst(rst),
            .f(f_if[i])
        ); // [RULE_01]
    end

    // ------------------------------------------------------------
    // Sampling, synchronisers and status outputs
    // ------------------------------------------------------------
    // Previous load level, taken only at each FIFO sample point
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_prev_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (samp_en[i]) begin
                    load_prev_reg[i] <= fifo_capture_load[i]; // [RULE_24]
                end
            end
        end
    end

    // Block status staged on the FIFO datapath clock
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (dp_en[i]) begin
                    sync1_reg[i] <= blk_stat_raw[i]; // [RULE_12]
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    end

    // Registered status and chain outputs; valid one edge after reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_status <= 2'h0;
            block_status <= 2'h0;
            chain_capture_out <= 2'h0;
        end else begin
            bus_status <= bus_stat_raw; // [RULE_16] [RULE_26]
            block_status <= blk_stat_sel; // [RULE_16]
            chain_capture_out <= chain_capture_out_next; // [RULE_11]
        end
    end

    // ------------------------------------------------------------
    // Accumulators and data registers
    // ------------------------------------------------------------
    // Accumulators: bus write, else FIFO, data register, ALU
    always_ff @(posedge clk_sys) begin
        if (rst || sleep) begin
            accumulator_zero <= RESET_BYTE; // [RULE_02]
            accumulator_one <= RESET_BYTE;
        end else begin
            if (wr_acc0) begin
                accumulator_zero <= bus_wr_data;
            end else if (dp_en[0] && dp_acc_from_fifo[0] && !out_dir[0]) begin
                accumulator_zero <= fifo_out[0]; // [RULE_04]
            end else if (dp_en[0] && dp_acc_from_data[0]) begin
                accumulator_zero <= data_reg_zero;
            end else if (dp_en[0] && dp_acc_from_alu[0]) begin
                accumulator_zero <= alu_result;
            end
            if (wr_acc1) begin
                accumulator_one <= bus_wr_data;
            end else if (dp_en[1] && dp_acc_from_fifo[1] && !out_dir[1]) begin
                accumulator_one <= fifo_out[1]; // [RULE_04]
            end else if (dp_en[1] && dp_acc_from_data[1]) begin
                accumulator_one <= data_reg_one;
            end else if (dp_en[1] && dp_acc_from_alu[1]) begin
                accumulator_one <= alu_result;
            end
        end
    end

    // Data registers: reset only, never cleared by sleep
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_reg_zero <= RESET_BYTE;
            data_reg_one <= RESET_BYTE;
        end else begin
            if (wr_data0) begin
                data_reg_zero <= bus_wr_data; // [RULE_03]
            end else if (dp_en[0] && dp_data_from_fifo[0] && !out_dir[0]) begin
                data_reg_zero <= fifo_out[0]; // [RULE_15]
            end
            if (wr_data1) begin
                data_reg_one <= bus_wr_data; // [RULE_03]
            end else if (dp_en[1] && dp_data_from_fifo[1] && !out_dir[1]) begin
                data_reg_one <= fifo_out[1]; // [RULE_15]
            end
        end
    end

    // ------------------------------------------------------------
    // Bus read data
    // ------------------------------------------------------------
    wire [7:0] rd_mux = hits(bus_addr, TGT_FIFO0) ? fifo_out[0] :
                        hits(bus_addr, TGT_FIFO1) ? fifo_out[1] :
                        hits(bus_addr, TGT_ACC0) ? accumulator_zero :
                        hits(bus_addr, TGT_ACC1) ? accumulator_one :
                        hits(bus_addr, TGT_DATA0) ? data_reg_zero :
                        hits(bus_addr, TGT_DATA1) ? data_reg_one : 8'h00;

    // Read data registered one cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_rd_data <= 8'h00;
        end else if (bus_rd_en) begin
            bus_rd_data <= rd_mux; // [RULE_05]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_load_low;
        samp_en[1] && !fifo_capture_load[1];
    endsequence

    sequence s_load_high;
        samp_en[1] && fifo_capture_load[1];
    endsequence

    a_level_every_cycle: assert property ((!edge_mode && out_dir[1]) ##0 s_load_high // [RULE_08]
        |-> f_if[1].push)
        else $error("level load did not push");
    a_edge_needs_low: assert property (edge_mode && hw_trig[1] // [RULE_23]
        |-> !load_prev_reg[1])
        else $error("edge capture without prior low");
    a_edge_no_repeat: assert property (s_load_low ##1 s_load_high ##1 // [RULE_23]
        (edge_mode && !sw_capture_en) ##0 s_load_high |-> !cap_fire[1])
        else $error("edge mode fired twice on one high");
    a_sleep_clears_acc: assert property (sleep |=> accumulator_zero == 8'h00 // [RULE_02]
        && accumulator_one == 8'h00)
        else $error("accumulator not cleared by sleep");
    a_data_keeps: assert property (sleep && !wr_data0 && !dp_data_from_fifo[0] // [RULE_03]
        |=> $stable(data_reg_zero))
        else $error("data register lost value in sleep");
    a_sw_capture_push: assert property (sw_capture_en && rd_acc0 && out_dir[0] // [RULE_10]
        |-> f_if[0].push)
        else $error("accumulator read did not capture");
    a_chain_forward: assert property (sw_capture_en && rd_acc1 // [RULE_11]
        |=> chain_capture_out[1])
        else $error("software capture not passed up the chain");
    a_block_direct: assert property (status_sync_mode == SYNC_DIRECT // [RULE_12]
        |=> block_status[0] == $past(blk_stat_raw[0]))
        else $error("direct block status mismatch");
    a_input_empty_stat: assert property (!out_dir[0] && !fifo_clear[0] // [RULE_18]
        && f_if[0].fill == '0 && status_sync_mode == SYNC_DIRECT |=> block_status[0])
        else $error("input empty not flagged");

    // Status thresholds and single-buffer status
    a_clear_no_bus: assert property (fifo_clear[0] // [RULE_06]
        |=> !bus_status[0])
        else $error("single buffer bus status set");
    a_output_full_stat: assert property (out_dir[1] && !fifo_clear[1] // [RULE_20]
        && f_if[1].fill == DEPTH_W && status_sync_mode == SYNC_DIRECT |=> block_status[1])
        else $error("output full not flagged");
    a_input_half_room: assert property (!out_dir[0] && fifo_level_threshold[0] // [RULE_17]
        && !fifo_clear[0] |=> bus_status[0] == ($past(f_if[0].fill) <= DEPTH_W - HALF_W))
        else $error("input bus threshold wrong");
endmodule : datapath_dual_fifo

// [verif/cpu_bus_model.sv]
// CPU model: byte writes and reads on the block's bus ports
`timescale 1ns/10ps
module cpu_bus_model (
    input wire logic clk_sys,
    input wire logic [7:0] bus_rd_data,
    output logic bus_wr_en,
    output logic bus_rd_en,
    output logic [2:0] bus_addr,
    output logic [7:0] bus_wr_data
);
    // Idle bus at time zero
    initial begin
        bus_wr_en = 1'b0;
        bus_rd_en = 1'b0;
        bus_addr = 3'h0;
        bus_wr_data = 8'h00;
    end
    // Write strobe, then a quiet cycle with inverted idle data
    task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
        bus_addr = a;
        bus_wr_data = d;
        bus_wr_en = 1'b1;
        @(posedge clk_sys);
        #1;
        bus_wr_en = 1'b0;
        bus_wr_data = ~d;
        @(posedge clk_sys);
        #1;
    endtask : bus_write
    // Read strobe; data is taken 1 ns after the taking edge
    task automatic bus_read(input logic [2:0] a, output logic [7:0] d);
        bus_addr = a;
        bus_rd_en = 1'b1;
        @(posedge clk_sys);
        #1;
        bus_rd_en = 1'b0;
        d = bus_rd_data;
    endtask : bus_read
endmodule : cpu_bus_model

// [verif/tb.sv]
// Self-checking bench for the dual datapath FIFO block
`timescale 1ns/10ps
module tb;
    import dual_fifo_pkg::*;
    logic clk_sys, rst, sleep, dp_clk_rise_en, dp_clk_fall_en, edge_mode, fast_mode;
    logic sw_capture_en, chain_enable, bus_wr_en, bus_rd_en;
    logic [1:0] fifo_source_select_zero, fifo_source_select_one, fifo_level_threshold;
    logic [1:0] fifo_clear, fifo_clk_invert, chain_capture_in, status_sync_mode;
    logic [1:0] fifo_capture_load, dp_acc_from_fifo, dp_data_from_fifo, dp_acc_from_data;
    logic [1:0] dp_acc_from_alu, bus_status, block_status, chain_capture_out;
    logic [2:0] bus_addr;
    logic [7:0] alu_result, bus_wr_data, bus_rd_data, rd;
    logic [7:0] accumulator_zero, accumulator_one, data_reg_zero, data_reg_one;
    int fail_count = 0;
    int checks_done = 0;
    datapath_dual_fifo #(.DEPTH(FIFO_DEPTH)) u_datapath_dual_fifo (
        .clk_sys, .rst, .sleep, .dp_clk_rise_en, .dp_clk_fall_en, .fifo_source_select_zero,
        .fifo_source_select_one, .fifo_level_threshold, .fifo_clear, .fifo_clk_invert,
        .edge_mode, .fast_mode, .sw_capture_en, .chain_enable, .chain_capture_in,
        .status_sync_mode, .fifo_capture_load, .alu_result, .dp_acc_from_fifo,
        .dp_data_from_fifo, .dp_acc_from_data, .dp_acc_from_alu, .bus_wr_en, .bus_rd_en,
        .bus_addr, .bus_wr_data, .bus_rd_data, .accumulator_zero, .accumulator_one,
        .data_reg_zero, .data_reg_one, .bus_status, .block_status, .chain_capture_out
    );
    cpu_bus_model u_cpu_bus_model (
        .clk_sys, .bus_rd_data, .bus_wr_en, .bus_rd_en, .bus_addr, .bus_wr_data
    );
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) clk_sys = ~clk_sys;
    end
    // Compare, count, report
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] got);
        checks_done++;
        if (got !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
            fail_count++;
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // Status settles two cycles after the cause
    task automatic stat(input logic [1:0] bus_e, input logic [1:0] blk_e);
        tick(2);
        check("bus_status", {6'h00, bus_e}, {6'h00, bus_status});
        check("block_status", {6'h00, blk_e}, {6'h00, block_status});
    endtask : stat
    task automatic rd_check(input logic [2:0] a, input logic [7:0] e);
        u_cpu_bus_model.bus_read(a, rd);
        check("bus_rd_data", e, rd);
        tick(1);
    endtask : rd_check
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // Watchdog, well past the test length
    initial begin
        #(CLK_PERIOD_NS * 4000);
        fail_count++;
        give_verdict();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        {sleep, dp_clk_fall_en, edge_mode, fast_mode, sw_capture_en, chain_enable} = '0;
        {fifo_source_select_zero, fifo_source_select_one, fifo_clear, fifo_clk_invert} = '0;
        {chain_capture_in, status_sync_mode, fifo_capture_load, dp_acc_from_fifo} = '0;
        {dp_data_from_fifo, dp_acc_from_data, dp_acc_from_alu, alu_result} = '0;
        dp_clk_rise_en = 1'b1;
        fifo_level_threshold = 2'h3;
        repeat (8) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        stat(2'h3, 2'h3);
        // Input direction: five writes into four places
        for (int i = 0; i < 5; i++) begin
            u_cpu_bus_model.bus_write(TGT_FIFO0, 8'hA0 + 8'(i));
            if (i == 1) stat(2'h3, 2'h2);
            if (i == 2) stat(2'h2, 2'h2);
        end
        fifo_level_threshold = 2'h0;
        stat(2'h2, 2'h2);
        // Datapath pops: the overflow byte replaced the front
        for (int i = 0; i < 4; i++) begin
            dp_acc_from_fifo = 2'h1;
            tick(1);
            dp_acc_from_fifo = 2'h0;
            check("accumulator_zero", (i == 0) ? 8'hA4 : 8'hA0 + 8'(i), accumulator_zero);
            tick(1);
        end
        stat(2'h3, 2'h3);
        // Underflow pop, then a normal byte through the data register
        dp_acc_from_fifo = 2'h1;
        tick(1);
        dp_acc_from_fifo = 2'h0;
        u_cpu_bus_model.bus_write(TGT_FIFO0, 8'h5C);
        dp_data_from_fifo = 2'h1;
        tick(1);
        dp_data_from_fifo = 2'h0;
        dp_acc_from_data = 2'h1;
        tick(1);
        dp_acc_from_data = 2'h0;
        check("accumulator_zero", 8'h5C, accumulator_zero);
        // Output direction from the ALU: normal, level, fast and edge loads
        fifo_source_select_one = SRC_ALU;
        stat(2'h1, 2'h1);
        dp_clk_rise_en = 1'b0;
        alu_result = 8'h77;
        fifo_capture_load = 2'h2;
        tick(1);
        dp_clk_rise_en = 1'b1;
        alu_result = 8'h3C;
        tick(1);
        alu_result = 8'h3D;
        tick(1);
        fifo_capture_load = 2'h0;
        dp_clk_rise_en = 1'b0;
        fast_mode = 1'b1;
        tick(1);
        edge_mode = 1'b1;
        alu_result = 8'h3E;
        fifo_capture_load = 2'h2;
        tick(3);
        fifo_capture_load = 2'h0;
        tick(1);
        alu_result = 8'h3F;
        fifo_capture_load = 2'h2;
        tick(1);
        fifo_capture_load = 2'h0;
        dp_clk_rise_en = 1'b1;
        stat(2'h3, 2'h3);
        for (int i = 0; i < 4; i++) rd_check(TGT_FIFO1, 8'h3C + 8'(i));
        // Accumulator one capture after an ALU load
        {edge_mode, fast_mode} = 2'h0;
        fifo_source_select_one = SRC_ACC1;
        alu_result = 8'h5A;
        dp_acc_from_alu = 2'h2;
        tick(1);
        dp_acc_from_alu = 2'h0;
        fifo_capture_load = 2'h2;
        tick(1);
        fifo_capture_load = 2'h0;
        rd_check(TGT_FIFO1, 8'h5A);
        // Software capture of accumulator zero
        fifo_source_select_zero = SRC_ACC0;
        sw_capture_en = 1'b1;
        u_cpu_bus_model.bus_write(TGT_ACC0, 8'h9A);
        u_cpu_bus_model.bus_read(TGT_ACC0, rd);
        check("chain_capture_out", 8'h01, {6'h00, chain_capture_out});
        tick(1);
        rd_check(TGT_FIFO0, 8'h9A);
        chain_enable = 1'b1;
        chain_capture_in = 2'h2;
        tick(1);
        chain_capture_in = 2'h0;
        check("chain_capture_out", 8'h02, {6'h00, chain_capture_out});
        rd_check(TGT_FIFO1, 8'h5A);
        sw_capture_en = 1'b0;
        // Single-byte buffer while held cleared
        fifo_source_select_zero = SRC_BUS;
        fifo_clear = 2'h1;
        u_cpu_bus_model.bus_write(TGT_FIFO0, 8'h11);
        u_cpu_bus_model.bus_write(TGT_FIFO0, 8'h22);
        rd_check(TGT_FIFO0, 8'h22);
        stat(2'h0, 2'h0);
        fifo_clear = 2'h0;
        // Sleep wipes accumulators, keeps data registers
        sleep = 1'b1;
        tick(1);
        sleep = 1'b0;
        tick(1);
        check("accumulator_one", 8'h00, accumulator_one);
        check("data_reg_zero", 8'h5C, data_reg_zero);
        give_verdict();
    end
endmodule : tb
